/* File: gpio_port_analog_shared_io.sv */
// GPIO ports 0, 1 and 6 with analog sharing, standby isolation and pulse remap
//
// Contract
// - Direction bit 1 makes the pin an output driving its latch bit.
// - Data writes always load the latch; output pins show it one clock later.
// - Reading an output pin's data returns the latch, not the pin.
// - Direction bit 0 makes an input; writes only load the latch.
// - Input pin read returns pin level; read-modify-write read returns latch.
// - Peripheral output enable drives the pin; reads return pin level.
// - Reads return pin level even while a peripheral uses it as input.
// - Analog-shared pin digital input is enabled only when its disable bit is 1.
// - Reset clears direction and analog-disable registers to 0.
// - Select 1 in stop/watch: pins float, inputs forced low and blocked.
// - In that isolation, interrupt-enabled pins keep their input path.
// - Select 0 in stop/watch: pin states and output levels are held.
// - Port 0 pin levels go to the external interrupt circuit; only in isolation are non-enabled pins blocked.
// - Pull-up bit 1 connects pull-up, except while the pin drives low; port 1 bit 2 has no pull-up.
// - Bits 0 and 3 comparator positive input enabled while gate bit is 0.
// - Bits 1 and 4 negative input enabled only when gate and source are 0.
// - Remap 0 sends pulses to port 1 bits 3,4,0,1,5,6; 1 to port 6 bits 2-7.
// - Register bit n of every port register controls pin n.
`timescale 1ns/1ns
module gpio_port_analog_shared_io #(
  parameter int PORT_WIDTH = gpio_port_pkg::PORT_WIDTH
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst,
  // Avalon-MM slave
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0]  avs_address,
  input  wire logic                                  avs_read,
  input  wire logic                                  avs_write,
  input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0]  avs_writedata,
  input  wire logic [3:0]                            avs_byteenable,
  output logic      [gpio_port_pkg::DATA_WIDTH-1:0]  avs_readdata,
  output logic                                       avs_waitrequest,
  // Pins
  input  wire logic [PORT_WIDTH-1:0]                 port0_pin_in,
  output logic      [PORT_WIDTH-1:0]                 port0_pin_out,
  output logic      [PORT_WIDTH-1:0]                 port0_pin_oe,
  output logic      [PORT_WIDTH-1:0]                 port0_pullup_on,
  input  wire logic [PORT_WIDTH-1:0]                 port1_pin_in,
  output logic      [PORT_WIDTH-1:0]                 port1_pin_out,
  output logic      [PORT_WIDTH-1:0]                 port1_pin_oe,
  output logic      [PORT_WIDTH-1:0]                 port1_pullup_on,
  input  wire logic [PORT_WIDTH-1:0]                 port6_pin_in,
  output logic      [PORT_WIDTH-1:0]                 port6_pin_out,
  output logic      [PORT_WIDTH-1:0]                 port6_pin_oe,
  // Shared peripherals
  input  wire logic [PORT_WIDTH-1:0]                 port0_periph_out,
  input  wire logic [PORT_WIDTH-1:0]                 port0_periph_oe,
  input  wire logic [gpio_port_pkg::PULSE_OUTS-1:0]  pulse_out,
  input  wire logic [gpio_port_pkg::PULSE_OUTS-1:0]  pulse_oe,
  input  wire logic                                  standby_entered,
  input  wire logic [PORT_WIDTH-1:0]                 ext_irq_enable,
  output logic      [PORT_WIDTH-1:0]                 ext_irq_level,
  output logic      [PORT_WIDTH-1:0]                 port0_digital_in,
  output logic      [PORT_WIDTH-1:0]                 port1_digital_in,
  output logic      [gpio_port_pkg::CMP_CHANNELS-1:0] cmp_pos_input_enable,
  output logic      [gpio_port_pkg::CMP_CHANNELS-1:0] cmp_neg_input_enable
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    gpio_port_pkg::bus_state_t bus_state;
    logic                      waitrequest;
    logic [31:0]               readdata;
    logic [7:0]                port0_output_latch;
    logic [7:0]                port0_direction;
    logic [7:0]                port0_pullup_enable;
    logic [7:0]                analog_input_disable_low;
    logic [7:0]                port1_output_latch;
    logic [7:0]                port1_direction;
    logic [7:0]                port1_pullup_enable;
    logic [7:0]                port6_output_latch;
    logic [7:0]                port6_direction;
    logic [7:0]                standby_control;
    logic [7:0]                comparator_ctrl_ch0;
    logic [7:0]                comparator_ctrl_ch1;
    logic [7:0]                system_config;
    logic [7:0]                p0_out;
    logic [7:0]                p0_oe;
    logic [7:0]                p0_pull;
    logic [7:0]                p1_out;
    logic [7:0]                p1_oe;
    logic [7:0]                p1_pull;
    logic [7:0]                p6_out;
    logic [7:0]                p6_oe;
    logic [7:0]                irq_level;
    logic [7:0]                p0_din;
    logic [7:0]                p1_din;
    logic [1:0]                cmp_pos;
    logic [1:0]                cmp_neg;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;

  logic [7:0] port0_sync;
  logic [7:0] port1_sync;
  logic [7:0] port6_sync;

  initial
  begin
    if (PORT_WIDTH != 8)
      $error("PORT_WIDTH must be 8: registers are one byte per port");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  pin_sync #(.WIDTH(8)) u_sync_port0 (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pin_in       (port0_pin_in),
    .pin_sync_out (port0_sync)
  );

  pin_sync #(.WIDTH(8)) u_sync_port1 (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pin_in       (port1_pin_in),
    .pin_sync_out (port1_sync)
  );

  pin_sync #(.WIDTH(8)) u_sync_port6 (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pin_in       (port6_pin_in),
    .pin_sync_out (port6_sync)
  );

  // ****************************************
  // Helpers
  // ****************************************
  // Plain data read: latch for GPIO outputs, pin level otherwise
  function automatic logic [7:0] data_read(input logic [7:0] latch, input logic [7:0] dir,
                                           input logic [7:0] poe, input logic [7:0] pin);
    logic [7:0] own;
    own       = dir & ~poe;
    data_read = (own & latch) | (~own & pin);
  endfunction

  // Pin value driven: peripheral wins over the latch
  function automatic logic [7:0] drive_value(input logic [7:0] latch, input logic [7:0] poe,
                                             input logic [7:0] pout);
    drive_value = (poe & pout) | (~poe & latch);
  endfunction

  // Pull-up connected unless the pin drives low
  function automatic logic [7:0] pull_value(input logic [7:0] pul, input logic [7:0] oe,
                                            input logic [7:0] dout, input logic [7:0] mask);
    pull_value = pul & mask & ~(oe & ~dout);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic [7:0] p1_poe;
  logic [7:0] p1_pout;
  logic [7:0] p6_poe;
  logic [7:0] p6_pout;
  logic       remap;
  logic       standby_iso;
  logic       standby_hold;
  logic [7:0] iso_block;
  logic [7:0] p0_pin_level;
  logic [7:0] p1_pin_level;
  logic [7:0] p6_pin_level;
  logic [7:0] wdata;
  logic       wr_fire;
  logic       req;
  logic [7:0] rd_byte;

  always_comb
  begin
    p1_poe  = 8'h00;
    p1_pout = 8'h00;
    p6_poe  = 8'h00;
    p6_pout = 8'h00;
    remap   = state.system_config[gpio_port_pkg::PULSE_OUT_REMAP_SELECT_BIT];
    for (int ch = 0; ch < gpio_port_pkg::PULSE_OUTS; ch++)
    begin
      if (!remap)
      begin
        p1_poe[gpio_port_pkg::PULSE_PORT1_BIT[ch]]  = pulse_oe[ch];
        p1_pout[gpio_port_pkg::PULSE_PORT1_BIT[ch]] = pulse_out[ch];
      end
      else
      begin
        p6_poe[gpio_port_pkg::PULSE_PORT6_BASE + ch]  = pulse_oe[ch];
        p6_pout[gpio_port_pkg::PULSE_PORT6_BASE + ch] = pulse_out[ch];
      end
    end

    standby_iso  = standby_entered &
                   state.standby_control[gpio_port_pkg::STANDBY_PIN_STATE_SELECT_BIT];
    standby_hold = standby_entered &
                   ~state.standby_control[gpio_port_pkg::STANDBY_PIN_STATE_SELECT_BIT];
    iso_block    = standby_iso ? ~ext_irq_enable : 8'h00;

    // Pin levels as seen by the core, port 0 gated by analog disable
    p0_pin_level = port0_sync & state.analog_input_disable_low & ~iso_block;
    p1_pin_level = standby_iso ? 8'h00 : port1_sync;
    p6_pin_level = standby_iso ? 8'h00 : port6_sync;

    next_state = state;

    // Outputs to pins, held while in standby with select 0
    if (!standby_hold)
    begin
      next_state.p0_oe   = standby_iso ? 8'h00 : (state.port0_direction | port0_periph_oe);
      next_state.p0_out  = drive_value(state.port0_output_latch, port0_periph_oe, port0_periph_out);
      next_state.p1_oe   = standby_iso ? 8'h00 : (state.port1_direction | p1_poe);
      next_state.p1_out  = drive_value(state.port1_output_latch, p1_poe, p1_pout);
      next_state.p6_oe   = standby_iso ? 8'h00 : (state.port6_direction | p6_poe);
      next_state.p6_out  = drive_value(state.port6_output_latch, p6_poe, p6_pout);
      next_state.p0_pull = pull_value(state.port0_pullup_enable, next_state.p0_oe, next_state.p0_out,
                                      gpio_port_pkg::PORT0_PULLUP_MASK);
      next_state.p1_pull = pull_value(state.port1_pullup_enable, next_state.p1_oe, next_state.p1_out,
                                      gpio_port_pkg::PORT1_PULLUP_MASK);
    end

    // Interrupt routing ignores port configuration
    next_state.irq_level = port0_sync & ~iso_block;
    next_state.p0_din    = p0_pin_level;
    next_state.p1_din    = p1_pin_level;

    // Comparator input gates on port 0 bits 0/3 and 1/4
    next_state.cmp_pos[0] = ~state.comparator_ctrl_ch0[gpio_port_pkg::COMPARATOR_INPUT_GATE_BIT];
    next_state.cmp_pos[1] = ~state.comparator_ctrl_ch1[gpio_port_pkg::COMPARATOR_INPUT_GATE_BIT];
    next_state.cmp_neg[0] = ~state.comparator_ctrl_ch0[gpio_port_pkg::COMPARATOR_INPUT_GATE_BIT] &
                            ~state.comparator_ctrl_ch0[gpio_port_pkg::NEG_INPUT_SOURCE_SELECT_BIT];
    next_state.cmp_neg[1] = ~state.comparator_ctrl_ch1[gpio_port_pkg::COMPARATOR_INPUT_GATE_BIT] &
                            ~state.comparator_ctrl_ch1[gpio_port_pkg::NEG_INPUT_SOURCE_SELECT_BIT];

    // Bus: one wait cycle, then the access completes
    req     = avs_read | avs_write;
    wdata   = avs_writedata[7:0];
    wr_fire = avs_write & avs_byteenable[0] & (state.bus_state == gpio_port_pkg::BUS_ACK);
    rd_byte = 8'h00;
    case (avs_address)
      gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH:
        rd_byte = data_read(state.port0_output_latch, state.port0_direction, port0_periph_oe, p0_pin_level);
      gpio_port_pkg::OFS_PORT0_LATCH_RMW:       rd_byte = state.port0_output_latch;
      gpio_port_pkg::OFS_PORT0_DIRECTION:       rd_byte = state.port0_direction;
      gpio_port_pkg::OFS_PORT0_PULLUP_ENABLE:   rd_byte = state.port0_pullup_enable;
      gpio_port_pkg::OFS_ANALOG_INPUT_DISABLE_LOW: rd_byte = state.analog_input_disable_low;
      gpio_port_pkg::OFS_PORT1_OUTPUT_LATCH:
        rd_byte = data_read(state.port1_output_latch, state.port1_direction, p1_poe, p1_pin_level);
      gpio_port_pkg::OFS_PORT1_LATCH_RMW:       rd_byte = state.port1_output_latch;
      gpio_port_pkg::OFS_PORT1_DIRECTION:       rd_byte = state.port1_direction;
      gpio_port_pkg::OFS_PORT1_PULLUP_ENABLE:   rd_byte = state.port1_pullup_enable;
      gpio_port_pkg::OFS_PORT6_OUTPUT_LATCH:
        rd_byte = data_read(state.port6_output_latch, state.port6_direction, p6_poe, p6_pin_level);
      gpio_port_pkg::OFS_PORT6_LATCH_RMW:       rd_byte = state.port6_output_latch;
      gpio_port_pkg::OFS_PORT6_DIRECTION:       rd_byte = state.port6_direction;
      gpio_port_pkg::OFS_STANDBY_CONTROL:
      begin
        rd_byte = state.standby_control;
        rd_byte[gpio_port_pkg::STANDBY_ACTIVE_BIT] = standby_entered;
      end
      gpio_port_pkg::OFS_COMPARATOR_CTRL_CH0:   rd_byte = state.comparator_ctrl_ch0;
      gpio_port_pkg::OFS_COMPARATOR_CTRL_CH1:   rd_byte = state.comparator_ctrl_ch1;
      gpio_port_pkg::OFS_SYSTEM_CONFIG:         rd_byte = state.system_config;
      default:                                  rd_byte = 8'h00;
    endcase

    case (state.bus_state)
      gpio_port_pkg::BUS_IDLE:
      begin
        next_state.waitrequest = 1'b1;
        if (req)
        begin
          next_state.bus_state   = gpio_port_pkg::BUS_ACK;
          next_state.waitrequest = 1'b0;
          next_state.readdata    = avs_read ? {24'h000000, rd_byte} : 32'h00000000;
        end
      end
      gpio_port_pkg::BUS_ACK:
      begin
        next_state.bus_state   = gpio_port_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
      default:
      begin
        next_state.bus_state   = gpio_port_pkg::BUS_IDLE;
        next_state.waitrequest = 1'b1;
      end
    endcase

    // Register writes at the completing edge
    if (wr_fire)
    begin
      case (avs_address)
        gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH,
        gpio_port_pkg::OFS_PORT0_LATCH_RMW:       next_state.port0_output_latch = wdata;
        gpio_port_pkg::OFS_PORT0_DIRECTION:       next_state.port0_direction = wdata;
        gpio_port_pkg::OFS_PORT0_PULLUP_ENABLE:   next_state.port0_pullup_enable = wdata;
        gpio_port_pkg::OFS_ANALOG_INPUT_DISABLE_LOW: next_state.analog_input_disable_low = wdata;
        gpio_port_pkg::OFS_PORT1_OUTPUT_LATCH,
        gpio_port_pkg::OFS_PORT1_LATCH_RMW:       next_state.port1_output_latch = wdata;
        gpio_port_pkg::OFS_PORT1_DIRECTION:       next_state.port1_direction = wdata;
        gpio_port_pkg::OFS_PORT1_PULLUP_ENABLE:   next_state.port1_pullup_enable = wdata;
        gpio_port_pkg::OFS_PORT6_OUTPUT_LATCH,
        gpio_port_pkg::OFS_PORT6_LATCH_RMW:       next_state.port6_output_latch = wdata;
        gpio_port_pkg::OFS_PORT6_DIRECTION:       next_state.port6_direction = wdata;
        gpio_port_pkg::OFS_STANDBY_CONTROL:
          next_state.standby_control = {1'b0, wdata[6:0]};
        gpio_port_pkg::OFS_COMPARATOR_CTRL_CH0:   next_state.comparator_ctrl_ch0 = wdata;
        gpio_port_pkg::OFS_COMPARATOR_CTRL_CH1:   next_state.comparator_ctrl_ch1 = wdata;
        gpio_port_pkg::OFS_SYSTEM_CONFIG:         next_state.system_config = wdata;
        default:
        begin
        end
      endcase
    end

    if (rst)
    begin
      next_state                          = '0;
      next_state.bus_state                = gpio_port_pkg::BUS_IDLE;
      next_state.waitrequest              = 1'b1;
      next_state.port0_output_latch       = gpio_port_pkg::RESET_PORT_REG;
      next_state.port0_direction          = gpio_port_pkg::RESET_PORT_REG;
      next_state.port0_pullup_enable      = gpio_port_pkg::RESET_PORT_REG;
      next_state.analog_input_disable_low = gpio_port_pkg::RESET_ANALOG_DIS;
      next_state.port1_output_latch       = gpio_port_pkg::RESET_PORT_REG;
      next_state.port1_direction          = gpio_port_pkg::RESET_PORT_REG;
      next_state.port1_pullup_enable      = gpio_port_pkg::RESET_PORT_REG;
      next_state.port6_output_latch       = gpio_port_pkg::RESET_PORT_REG;
      next_state.port6_direction          = gpio_port_pkg::RESET_PORT_REG;
      next_state.standby_control          = gpio_port_pkg::RESET_CTRL_REG;
      next_state.comparator_ctrl_ch0      = gpio_port_pkg::RESET_CTRL_REG;
      next_state.comparator_ctrl_ch1      = gpio_port_pkg::RESET_CTRL_REG;
      next_state.system_config            = gpio_port_pkg::RESET_CTRL_REG;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata         = state.readdata;
  assign avs_waitrequest      = state.waitrequest;
  assign port0_pin_out        = state.p0_out;
  assign port0_pin_oe         = state.p0_oe;
  assign port0_pullup_on      = state.p0_pull;
  assign port1_pin_out        = state.p1_out;
  assign port1_pin_oe         = state.p1_oe;
  assign port1_pullup_on      = state.p1_pull;
  assign port6_pin_out        = state.p6_out;
  assign port6_pin_oe         = state.p6_oe;
  assign ext_irq_level        = state.irq_level;
  assign port0_digital_in     = state.p0_din;
  assign port1_digital_in     = state.p1_din;
  assign cmp_pos_input_enable = state.cmp_pos;
  assign cmp_neg_input_enable = state.cmp_neg;

endmodule

/* File: gpio_port_pkg.sv */
// Shared constants for the analog-shared GPIO port block
package gpio_port_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int PORT_WIDTH   = 8;
  localparam int ADDR_WIDTH   = 6;
  localparam int DATA_WIDTH   = 32;
  localparam int PULSE_OUTS   = 6;
  localparam int CMP_CHANNELS = 2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_PORT0_OUTPUT_LATCH         = 6'h00;
  localparam logic [5:0] OFS_PORT0_LATCH_RMW            = 6'h04;
  localparam logic [5:0] OFS_PORT0_DIRECTION            = 6'h08;
  localparam logic [5:0] OFS_PORT0_PULLUP_ENABLE        = 6'h0c;
  localparam logic [5:0] OFS_ANALOG_INPUT_DISABLE_LOW   = 6'h10;
  localparam logic [5:0] OFS_PORT1_OUTPUT_LATCH         = 6'h14;
  localparam logic [5:0] OFS_PORT1_LATCH_RMW            = 6'h18;
  localparam logic [5:0] OFS_PORT1_DIRECTION            = 6'h1c;
  localparam logic [5:0] OFS_PORT1_PULLUP_ENABLE        = 6'h20;
  localparam logic [5:0] OFS_PORT6_OUTPUT_LATCH         = 6'h24;
  localparam logic [5:0] OFS_PORT6_LATCH_RMW            = 6'h28;
  localparam logic [5:0] OFS_PORT6_DIRECTION            = 6'h2c;
  localparam logic [5:0] OFS_STANDBY_CONTROL            = 6'h30;
  localparam logic [5:0] OFS_COMPARATOR_CTRL_CH0        = 6'h34;
  localparam logic [5:0] OFS_COMPARATOR_CTRL_CH1        = 6'h38;
  localparam logic [5:0] OFS_SYSTEM_CONFIG              = 6'h3c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STANDBY_PIN_STATE_SELECT_BIT = 0;
  localparam int STANDBY_ACTIVE_BIT           = 7;
  localparam int COMPARATOR_INPUT_GATE_BIT    = 0;
  localparam int NEG_INPUT_SOURCE_SELECT_BIT  = 1;
  localparam int PULSE_OUT_REMAP_SELECT_BIT   = 0;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] RESET_PORT_REG      = 8'h00;
  localparam logic [7:0] RESET_ANALOG_DIS    = 8'h00;
  localparam logic [7:0] RESET_CTRL_REG      = 8'h00;
  localparam logic [7:0] PORT0_PULLUP_MASK   = 8'hff;
  localparam logic [7:0] PORT1_PULLUP_MASK   = 8'hfb;
  localparam logic [7:0] PORT6_REMAP_MASK    = 8'hfc;

  // Pulse channel to port 1 bit, channel order gen0a,gen0b,gen1a,gen1b,gen2a,gen2b
  localparam logic [2:0] PULSE_PORT1_BIT [PULSE_OUTS] = '{3'h3, 3'h4, 3'h0, 3'h1, 3'h5, 3'h6};
  localparam int         PULSE_PORT6_BASE = 2;

  typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

/* File: pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync WIDTH must be positive");
  end

  always_comb
  begin
    next_state        = state;
    next_state.meta   = pin_in;
    next_state.stable = state.meta;
    if (rst)
      next_state = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  assign pin_sync_out = state.stable;

endmodule

/* File: gpio_pad_model.sv */
// Pad model: pin level from own drive, pull-up or outside level
`timescale 1ns/1ns
module gpio_pad_model (
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pu,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin
);
  assign pin = (oe & out) | (~oe & pu) | (~oe & ~pu & ext);
endmodule

/* File: gpio_port_monitor.sv */
// Concurrent checks on the GPIO port pins and bus
`timescale 1ns/1ns
module gpio_port_monitor (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  port0_pin_in,
  input wire logic [7:0]  port0_pin_out,
  input wire logic [7:0]  port0_pin_oe,
  input wire logic [7:0]  port0_pullup_on,
  input wire logic [7:0]  port0_periph_out,
  input wire logic [7:0]  port0_periph_oe,
  input wire logic [7:0]  port1_pin_oe,
  input wire logic [7:0]  port6_pin_oe,
  input wire logic [5:0]  pulse_oe,
  input wire logic        standby_entered,
  input wire logic [7:0]  ext_irq_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence awake2; !standby_entered [*2]; endsequence
  sequence awake4; (!standby_entered && !rst) [*4]; endsequence
  AST_RESET_OE: assert property ($fell(rst) |-> (port0_pin_oe | port1_pin_oe) == 8'h00)
    else $error("drive on after reset");
  AST_PULLUP_LOW: assert property ((port0_pullup_on & port0_pin_oe & ~port0_pin_out) == 8'h00)
    else $error("pull-up on low pin");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  AST_READ_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_IRQ_ROUTE: assert property (awake4 |-> ext_irq_level == $past(port0_pin_in, 3))
    else $error("irq level wrong");
  AST_PERIPH_OE: assert property (awake2 |-> (port0_pin_oe & $past(port0_periph_oe)) == $past(port0_periph_oe))
    else $error("peripheral not driving");
  AST_PERIPH_OUT: assert property (awake2 |-> ((port0_pin_out ^ $past(port0_periph_out)) & $past(port0_periph_oe)) == 8'h00)
    else $error("peripheral value lost");
  AST_PULSE_ROUTE: assert property (awake2 |-> !$past(pulse_oe[0]) || port1_pin_oe[3] || port6_pin_oe[2])
    else $error("pulse not routed");
endmodule
bind gpio_port_analog_shared_io gpio_port_monitor gpio_port_monitor_i (.clk_sys, .rst, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .port0_pin_in, .port0_pin_out, .port0_pin_oe, .port0_pullup_on,
  .port0_periph_out, .port0_periph_oe, .port1_pin_oe, .port6_pin_oe, .pulse_oe, .standby_entered, .ext_irq_level);

/* File: gpio_port_analog_shared_io_test.sv */
// Self-checking bench for the analog-shared GPIO port
`timescale 1ns/1ns
module gpio_port_analog_shared_io_test;
  logic        clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, standby_entered = 1'b0;
  logic        avs_waitrequest;
  logic [5:0]  avs_address = 6'h00, pulse_out = 6'h15, pulse_oe = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0]  port0_pin_in, port0_pin_out, port0_pin_oe, port0_pullup_on, port1_pin_in, port1_pin_out;
  logic [7:0]  port1_pin_oe, port1_pullup_on, port6_pin_in, port6_pin_out, port6_pin_oe, ext_irq_level;
  logic [7:0]  port0_digital_in, port1_digital_in, port0_periph_out = 8'h00, port0_periph_oe = 8'h00;
  logic [7:0]  ext_irq_enable = 8'h00, ext0 = 8'h3c, ext1 = 8'h5a, ext6 = 8'ha5;
  logic [1:0]  cmp_pos_input_enable, cmp_neg_input_enable;
  int          checks = 0, miscompares = 0;
  initial forever #50 clk_sys = ~clk_sys;
  gpio_pad_model pad0 (.out(port0_pin_out), .oe(port0_pin_oe), .pu(port0_pullup_on), .ext(ext0), .pin(port0_pin_in));
  gpio_pad_model pad1 (.out(port1_pin_out), .oe(port1_pin_oe), .pu(port1_pullup_on), .ext(ext1), .pin(port1_pin_in));
  gpio_pad_model pad6 (.out(port6_pin_out), .oe(port6_pin_oe), .pu(8'h00), .ext(ext6), .pin(port6_pin_in));
  gpio_port_analog_shared_io gpio_port_analog_shared_io_i (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .port0_pin_in, .port0_pin_out,
    .port0_pin_oe, .port0_pullup_on, .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pullup_on,
    .port6_pin_in, .port6_pin_out, .port6_pin_oe, .port0_periph_out, .port0_periph_oe, .pulse_out, .pulse_oe,
    .standby_entered, .ext_irq_enable, .ext_irq_level, .port0_digital_in, .port1_digital_in,
    .cmp_pos_input_enable, .cmp_neg_input_enable);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    chk(n, q, {24'h000000, e});
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #1000000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(gpio_port_pkg::OFS_PORT0_DIRECTION, 8'h00, "dir0");
    rdc(gpio_port_pkg::OFS_ANALOG_INPUT_DISABLE_LOW, 8'h00, "aidr");
    bus(1'b1, gpio_port_pkg::OFS_PORT0_PULLUP_ENABLE, 8'hff);
    bus(1'b1, gpio_port_pkg::OFS_PORT0_DIRECTION, 8'hff);
    bus(1'b1, gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h0f);
    repeat (4) @(posedge clk_sys);
    chk("oe0", port0_pin_oe, 8'hff);
    chk("out0", port0_pin_out, 8'h0f);
    chk("pu0", port0_pullup_on, 8'h0f);
    rdc(gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h0f, "lat0");
    $display("test output done");
    bus(1'b1, gpio_port_pkg::OFS_PORT0_PULLUP_ENABLE, 8'h00);
    bus(1'b1, gpio_port_pkg::OFS_PORT0_DIRECTION, 8'h00);
    bus(1'b1, gpio_port_pkg::OFS_ANALOG_INPUT_DISABLE_LOW, 8'hff);
    bus(1'b1, gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'ha5);
    repeat (4) @(posedge clk_sys);
    chk("oe0", port0_pin_oe, 8'h00);
    rdc(gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h3c, "pin0");
    rdc(gpio_port_pkg::OFS_PORT0_LATCH_RMW, 8'ha5, "rmw0");
    port0_periph_out <= 8'h01;
    port0_periph_oe <= 8'h01;
    repeat (4) @(posedge clk_sys);
    rdc(gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h3d, "per0");
    rdc(gpio_port_pkg::OFS_PORT0_LATCH_RMW, 8'ha5, "rmwp");
    chk("irq", ext_irq_level, 8'h3d);
    port0_periph_oe <= 8'h00;
    bus(1'b1, gpio_port_pkg::OFS_ANALOG_INPUT_DISABLE_LOW, 8'hf0);
    repeat (4) @(posedge clk_sys);
    chk("din0", port0_digital_in, 8'h30);
    $display("test input done");
    ext_irq_enable <= 8'h30;
    bus(1'b1, gpio_port_pkg::OFS_PORT0_DIRECTION, 8'hff);
    bus(1'b1, gpio_port_pkg::OFS_STANDBY_CONTROL, 8'h01);
    standby_entered <= 1'b1;
    ext0 <= 8'hf0;
    repeat (6) @(posedge clk_sys);
    chk("iso", port0_pin_oe | port1_pin_oe, 8'h00);
    chk("isodin", port0_digital_in, 8'h30);
    chk("isod1", port1_digital_in, 8'h00);
    standby_entered <= 1'b0;
    bus(1'b1, gpio_port_pkg::OFS_STANDBY_CONTROL, 8'h00);
    standby_entered <= 1'b1;
    bus(1'b1, gpio_port_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h5a);
    repeat (4) @(posedge clk_sys);
    chk("hold", port0_pin_oe, 8'hff);
    chk("holdv", port0_pin_out, 8'ha5);
    standby_entered <= 1'b0;
    $display("test standby done");
    for (int g = 0; g < 4; g++)
    begin
      bus(1'b1, gpio_port_pkg::OFS_COMPARATOR_CTRL_CH0, g[7:0]);
      repeat (4) @(posedge clk_sys);
      chk("cpos", cmp_pos_input_enable, {1'b1, !g[0]});
      chk("cneg", cmp_neg_input_enable, {1'b1, !(g[0] || g[1])});
    end
    pulse_oe <= 6'h3f;
    repeat (4) @(posedge clk_sys);
    chk("p1oe", port1_pin_oe, 8'h7b);
    chk("p1out", port1_pin_out & 8'h7b, 8'h29);
    bus(1'b1, gpio_port_pkg::OFS_SYSTEM_CONFIG, 8'h01);
    repeat (4) @(posedge clk_sys);
    chk("p6oe", port6_pin_oe, 8'hfc);
    chk("p6out", port6_pin_out & 8'hfc, 8'h54);
    $display("test compare and remap done");
    end_sim;
  end
endmodule
